/* src/registered_prom_read.v */
// registered fuse memory read path with enables and fuse blow sequencer
`timescale 1ns/1ps
`include "prom_map.vh"

module registered_prom_read (
  input  wire                       clock_i,
  input  wire                       resetn_i,
  input  wire                       clk_en_i,
  input  wire [`PROM_ADDR_W-1:0]    word_select_i,
  input  wire                       sync_out_enable_n_i,
  input  wire                       async_out_enable_n_i,
  input  wire                       init_load_n_i,
  input  wire                       prog_start_i,
  input  wire                       prog_init_word_i,
  input  wire [`PROM_BIT_SEL_W-1:0] prog_bit_i,
  output wire [`PROM_DATA_W-1:0]    data_out_o,
  output wire                       data_oe_n_o,
  output reg                        prog_busy_o,
  output reg                        prog_done_o,
  output reg                        prog_error_o
);

  // ----------------------------------------------------------------------
  // overview
  // ----------------------------------------------------------------------
  // read path:
  //   word select and initialize are taken at an enabled rising edge
  //   the chosen word sits in the output register until the next one
  //   sync enable is kept in a flop of its own, taken at the same edge
  //   async enable is or-ed in after that flop, with no clock involved
  // blow path:
  //   a start is honoured only in idle and with the outputs off
  //   the target word, bit and destination are captured at that edge
  //   one bit per sequence; a blown bit can never read zero again
  //   busy covers the first pulse and the extra reinforcing pulses
  //   done and error are sticky until the next accepted start
  // clock enable:
  //   low freezes every flop, fuses and sequencer counters included
  //   so a stalled clock enable also stretches the blow pulses
  // reset:
  //   synchronous and active low, applied whatever the clock enable
  //   clears the data register, the sequencer and the flags
  //   leaves the sync flop in the off state
  //   never touches fuse contents, which are nonvolatile
  // hazards for the user:
  //   driver enable is not a pure flop output, by intent
  //   a glitch on the async pin reaches the drivers directly
  //   a start while busy is dropped without any flag
  //   a start with the outputs on raises error and blows nothing
  //   reads during a blow sequence still work; the blown bit shows once the first pulse ends

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_BLOW  = 4'h2;
  localparam [3:0] ST_EXTRA = 4'h4;
  localparam [3:0] ST_DONE  = 4'h8;

  // last count values, worked out wide and cut to counter width
  localparam integer PULSE_LAST_INT = `PROM_PULSE_CYC - 1;
  localparam integer EXTRA_LAST_INT = `PROM_EXTRA_PULSES - 1;
  localparam [`PROM_CNT_W-1:0] PULSE_LAST =
    PULSE_LAST_INT[`PROM_CNT_W-1:0];
  localparam [`PROM_PULSE_CNT_W-1:0] EXTRA_LAST =
    EXTRA_LAST_INT[`PROM_PULSE_CNT_W-1:0];

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg                          sync_off_reg;
  reg  [3:0]                   state_reg;
  reg  [3:0]                   state_next;
  reg  [`PROM_CNT_W-1:0]       pulse_cnt_reg;
  reg  [`PROM_CNT_W-1:0]       pulse_cnt_next;
  reg  [`PROM_PULSE_CNT_W-1:0] extra_cnt_reg;
  reg  [`PROM_PULSE_CNT_W-1:0] extra_cnt_next;
  reg  [`PROM_ADDR_W-1:0]      tgt_addr_reg;
  reg  [`PROM_DATA_W-1:0]      tgt_mask_reg;
  reg                          tgt_init_reg;
  reg                          busy_next;
  reg                          done_next;
  reg                          error_next;
  reg                          blow_now;
  wire                         pulse_end;
  wire                         start_ok;
  wire                         array_blow;
  wire                         init_blow;
  wire [`PROM_DATA_W-1:0]      init_word;
  wire [`PROM_DATA_W-1:0]      bit_mask;

  // ----------------------------------------------------------------------
  // synchronous output enable flop
  // ----------------------------------------------------------------------

  // the flop starts off, so nothing drives the bus out of reset
  // its value only moves at an enabled edge, never in between
  // removing the sync enable after the edge has no effect
  // sampled only at the edge, so later changes do not matter
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      sync_off_reg <= `PROM_OFF_RST;
    end else if (clk_en_i) begin
      sync_off_reg <= sync_out_enable_n_i;
    end
  end

  // ----------------------------------------------------------------------
  // output driver enable
  // ----------------------------------------------------------------------

  // low means the drivers are on
  // either enable high is enough to turn them off
  // the async pin is not registered, so it acts at once
  // the data register is not touched by the async pin
  // the sequencer insists on this being off before it blows
  // async enable bypasses the clock and leaves data untouched
  assign data_oe_n_o = sync_off_reg | async_out_enable_n_i;
  // drivers on only when both enables are low
  // no flop between the async pin and the drivers

  // ----------------------------------------------------------------------
  // data register and fuse storage
  // ----------------------------------------------------------------------

  // the array word flows ahead of the edge like a master stage
  // the register inside the memory module is the slave stage
  // initialize low picks the extra word instead of the array
  // the register loads even while the drivers are off
  // so a later enable shows the word taken at the last edge
  // word select is applied by the host ahead of the edge
  // register only loads on an enabled edge
  fuse_array_mem u_array (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .ce_i        (clk_en_i),
    .rd_addr_i   (word_select_i),
    .load_init_i (~init_load_n_i),
    .init_word_i (init_word),
    .blow_i      (array_blow),
    .blow_addr_i (tgt_addr_reg),
    .blow_mask_i (tgt_mask_reg),
    .rd_data_o   (data_out_o)
  );

  // extra word, blank until a bit of it is blown
  init_word_fuse u_init (
    .clock_i     (clock_i),
    .ce_i        (clk_en_i),
    .blow_i      (init_blow),
    .blow_mask_i (tgt_mask_reg),
    .word_o      (init_word)
  );

  // ----------------------------------------------------------------------
  // fuse blow control
  // ----------------------------------------------------------------------

  // timing of one sequence, in enabled edges after the start edge:
  //   edge 1 onward   busy high, first pulse counting
  //   edge 2000       fuse bit opens, blow strobe for one cycle
  //   next 10000      five extra pulses of the same length
  //   edge 12001      busy low, done high, back to idle
  // the extra pulses have no visible effect beyond the time taken
  // the pulse counter restarts at zero at the start of every pulse
  // one bit at a time; start only with outputs disabled
  assign bit_mask  = `PROM_ONE_BIT << prog_bit_i;
  assign start_ok  = async_out_enable_n_i;
  assign pulse_end = (pulse_cnt_reg == PULSE_LAST);

  // the fuse opens at the end of the first pulse
  assign array_blow = blow_now & ~tgt_init_reg;
  assign init_blow  = blow_now & tgt_init_reg;

  // capture target word, bit and destination on an accepted start
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      tgt_addr_reg <= `PROM_LAST_ADDR;
      tgt_mask_reg <= `PROM_BLANK_WORD;
      tgt_init_reg <= 1'b0;
    end else if (clk_en_i) begin
      if ((state_reg == ST_IDLE) && prog_start_i && start_ok) begin
        tgt_addr_reg <= word_select_i;
        tgt_mask_reg <= bit_mask;
        tgt_init_reg <= prog_init_word_i;
      end
    end
  end

  // next state: first pulse, then the extra reinforcing pulses
  always @* begin
    state_next     = state_reg;
    pulse_cnt_next = pulse_cnt_reg;
    extra_cnt_next = extra_cnt_reg;
    busy_next      = prog_busy_o;
    done_next      = prog_done_o;
    error_next     = prog_error_o;
    blow_now       = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (prog_start_i) begin
          if (start_ok) begin
            state_next     = ST_BLOW;
            pulse_cnt_next = {`PROM_CNT_W{1'b0}};
            busy_next      = 1'b1;
            done_next      = 1'b0;
            error_next     = 1'b0;
          end else begin
            error_next = 1'b1;
          end
        end
      end
      ST_BLOW: begin
        if (pulse_end) begin
          blow_now       = 1'b1;
          state_next     = ST_EXTRA;
          pulse_cnt_next = {`PROM_CNT_W{1'b0}};
          extra_cnt_next = {`PROM_PULSE_CNT_W{1'b0}};
        end else begin
          pulse_cnt_next = pulse_cnt_reg + 1'b1;
        end
      end
      ST_EXTRA: begin
        if (pulse_end) begin
          pulse_cnt_next = {`PROM_CNT_W{1'b0}};
          if (extra_cnt_reg == EXTRA_LAST) begin
            state_next = ST_DONE;
          end else begin
            extra_cnt_next = extra_cnt_reg + 1'b1;
          end
        end else begin
          pulse_cnt_next = pulse_cnt_reg + 1'b1;
        end
      end
      ST_DONE: begin
        busy_next  = 1'b0;
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
        busy_next  = 1'b0;
      end
    endcase
  end

  // flags come straight from these flops
  // reset leaves the sequencer idle with every flag low
  // sequencer registers, frozen while the clock enable is low
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      state_reg     <= ST_IDLE;
      pulse_cnt_reg <= {`PROM_CNT_W{1'b0}};
      extra_cnt_reg <= {`PROM_PULSE_CNT_W{1'b0}};
      prog_busy_o   <= 1'b0;
      prog_done_o   <= 1'b0;
      prog_error_o  <= 1'b0;
    end else if (clk_en_i) begin
      state_reg     <= state_next;
      pulse_cnt_reg <= pulse_cnt_next;
      extra_cnt_reg <= extra_cnt_next;
      prog_busy_o   <= busy_next;
      prog_done_o   <= done_next;
      prog_error_o  <= error_next;
    end
  end

endmodule // registered_prom_read

/* src/prom_map.vh */
// constants shared by the registered fuse memory read path
`ifndef PROM_MAP_VH
`define PROM_MAP_VH

// ----------------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------------
`define PROM_WORDS        1024
`define PROM_ADDR_W       10
`define PROM_DATA_W       8
`define PROM_BIT_SEL_W    3
`define PROM_LAST_ADDR    10'h3ff

// ----------------------------------------------------------------------
// reset and unprogrammed values
// ----------------------------------------------------------------------
`define PROM_BLANK_WORD   8'h00
`define PROM_ONE_BIT      8'h01
`define PROM_DATA_RST     8'h00
`define PROM_OFF_RST      1'b1

// ----------------------------------------------------------------------
// fuse blow timing
// ----------------------------------------------------------------------
`define PROM_CLK_PERIOD_NS  5
`define PROM_PULSE_NS       10000
`define PROM_PULSE_CYC      (`PROM_PULSE_NS / `PROM_CLK_PERIOD_NS)
`define PROM_CNT_W          11
`define PROM_EXTRA_PULSES   5
`define PROM_PULSE_CNT_W    3

`endif

/* src/fuse_array_mem.v */
// fuse array of 1024 words by 8 bits with a registered read port
`timescale 1ns/1ps
`include "prom_map.vh"

module fuse_array_mem (
  input  wire                       clock_i,
  input  wire                       resetn_i,
  input  wire                       ce_i,
  input  wire [`PROM_ADDR_W-1:0]    rd_addr_i,
  input  wire                       load_init_i,
  input  wire [`PROM_DATA_W-1:0]    init_word_i,
  input  wire                       blow_i,
  input  wire [`PROM_ADDR_W-1:0]    blow_addr_i,
  input  wire [`PROM_DATA_W-1:0]    blow_mask_i,
  output reg  [`PROM_DATA_W-1:0]    rd_data_o
);

  reg [`PROM_DATA_W-1:0] fuse_mem [0:`PROM_WORDS-1];
  integer                idx;

  // every fuse intact at start, so every word reads zero
  initial begin
    for (idx = 0; idx < `PROM_WORDS; idx = idx + 1) begin
      fuse_mem[idx] = `PROM_BLANK_WORD;
    end
  end

  // a blown fuse only ever adds ones
  always @(posedge clock_i) begin
    if (ce_i && blow_i) begin
      fuse_mem[blow_addr_i] <= fuse_mem[blow_addr_i] | blow_mask_i;
    end
  end

  // slave stage: array word or initialize word taken at the edge
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      rd_data_o <= `PROM_DATA_RST;
    end else if (ce_i) begin
      if (load_init_i) begin
        rd_data_o <= init_word_i;
      end else begin
        rd_data_o <= fuse_mem[rd_addr_i];
      end
    end
  end

endmodule // fuse_array_mem

/* src/init_word_fuse.v */
// extra programmable initialize word, one fuse per bit
`timescale 1ns/1ps
`include "prom_map.vh"

module init_word_fuse (
  input  wire                     clock_i,
  input  wire                     ce_i,
  input  wire                     blow_i,
  input  wire [`PROM_DATA_W-1:0]  blow_mask_i,
  output wire [`PROM_DATA_W-1:0]  word_o
);

  genvar bit_idx;

  // one sticky fuse per bit of the word
  generate
    for (bit_idx = 0; bit_idx < `PROM_DATA_W; bit_idx = bit_idx + 1)
    begin : g_fuse
      reg fuse_reg;
      initial begin
        fuse_reg = 1'b0;
      end
      always @(posedge clock_i) begin
        if (ce_i && blow_i && blow_mask_i[bit_idx]) begin
          fuse_reg <= 1'b1;
        end
      end
      assign word_o[bit_idx] = fuse_reg;
    end
  endgenerate

endmodule // init_word_fuse

/* sim/data_bus_model.sv */
// model of the host data bus fed by the fuse memory outputs
`timescale 1ns/1ps
module data_bus_model (
  input  wire       clock_i,
  input  wire [7:0] data_i,
  input  wire       oe_n_i,
  output wire [7:0] bus_o
);
  // last driven word, shown inverted once released so stale data never matches
  reg [7:0] last_reg = 8'h00;
  always @(posedge clock_i) if (!oe_n_i) last_reg <= data_i;
  assign bus_o = oe_n_i ? ~last_reg : data_i;
endmodule // data_bus_model

/* sim/prom_read_monitor.sv */
// assertion checker for the registered fuse memory read path
`timescale 1ns/1ps
module prom_read_monitor (
  input wire       clock_i,
  input wire       resetn_i,
  input wire       clk_en_i,
  input wire       sync_out_enable_n_i,
  input wire       async_out_enable_n_i,
  input wire       prog_start_i,
  input wire [7:0] data_out_o,
  input wire       data_oe_n_o,
  input wire       prog_busy_o,
  input wire       prog_done_o,
  input wire       prog_error_o
);
  // --------------------------------------------------------------------
  // helper logic
  // --------------------------------------------------------------------
  // counts enabled edges while a blow sequence runs
  reg [13:0] busy_cnt_reg;
  always @(posedge clock_i)
    if (!resetn_i || !prog_busy_o) busy_cnt_reg <= 14'h0000;
    else if (clk_en_i) busy_cnt_reg <= busy_cnt_reg + 14'h0001;
  wire start_idle = clk_en_i && prog_start_i && !prog_busy_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  async_off_a: assert property (async_out_enable_n_i |-> data_oe_n_o)
    else $error("outputs driven with async enable high");
  sync_off_a: assert property ((clk_en_i && sync_out_enable_n_i) |=> data_oe_n_o)
    else $error("outputs driven after sync enable high");
  both_on_a: assert property ((clk_en_i && !sync_out_enable_n_i) ##1
    !async_out_enable_n_i |-> !data_oe_n_o)
    else $error("outputs off with both enables low");
  reset_state_a: assert property ($rose(resetn_i) |->
    data_oe_n_o && data_out_o == 8'h00)
    else $error("wrong state after reset");
  hold_data_a: assert property (!clk_en_i |=> $stable(data_out_o))
    else $error("data changed without an enabled edge");
  hold_oe_a: assert property ((!clk_en_i ##1 $stable(async_out_enable_n_i))
    |-> $stable(data_oe_n_o))
    else $error("enable changed without an enabled edge");
  start_taken_a: assert property ((start_idle && async_out_enable_n_i) |=>
    prog_busy_o && !prog_done_o && !prog_error_o)
    else $error("accepted start did not begin a sequence");
  start_refused_a: assert property ((start_idle && !async_out_enable_n_i) |=>
    prog_error_o && !prog_busy_o)
    else $error("start with outputs on was not refused");
  blow_done_a: assert property ($fell(prog_busy_o) |-> prog_done_o &&
    busy_cnt_reg >= 14'h2ee0 && busy_cnt_reg <= 14'h2ee2)
    else $error("blow sequence length or done wrong");
endmodule // prom_read_monitor

bind registered_prom_read prom_read_monitor i_mon (
  .clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
  .sync_out_enable_n_i(sync_out_enable_n_i), .prog_start_i(prog_start_i),
  .async_out_enable_n_i(async_out_enable_n_i), .data_out_o(data_out_o),
  .data_oe_n_o(data_oe_n_o), .prog_busy_o(prog_busy_o),
  .prog_done_o(prog_done_o), .prog_error_o(prog_error_o));

/* sim/registered_prom_read_test.sv */
// self-checking bench for the registered fuse memory read path
`timescale 1ns/1ps
module registered_prom_read_test;
  reg        clock_i = 1'b0;
  reg        resetn_i = 1'b0;
  reg        clk_en_i = 1'b1;
  reg  [9:0] word_select_i = 10'h000;
  reg        sync_out_enable_n_i = 1'b1;
  reg        async_out_enable_n_i = 1'b1;
  reg        init_load_n_i = 1'b1;
  reg        prog_start_i = 1'b0;
  reg        prog_init_word_i = 1'b0;
  reg  [2:0] prog_bit_i = 3'h0;
  wire [7:0] data_out_o, bus;
  wire       data_oe_n_o, prog_busy_o, prog_done_o, prog_error_o;
  reg  [7:0] exp_mem [0:1023];
  reg  [7:0] exp_init = 8'h00;
  reg  [8:0] notes [$];
  reg        req = 1'b0, look = 1'b0;
  reg  [9:0] addr_a;
  integer    mismatches = 0, samples_checked = 0, cycles = 0, i, j, r;
  integer    seed = 32'hebc70408;
  registered_prom_read i_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
    .word_select_i(word_select_i), .sync_out_enable_n_i(sync_out_enable_n_i),
    .async_out_enable_n_i(async_out_enable_n_i), .init_load_n_i(init_load_n_i),
    .prog_start_i(prog_start_i), .prog_init_word_i(prog_init_word_i),
    .prog_bit_i(prog_bit_i), .data_out_o(data_out_o), .data_oe_n_o(data_oe_n_o),
    .prog_busy_o(prog_busy_o), .prog_done_o(prog_done_o),
    .prog_error_o(prog_error_o));
  data_bus_model i_bus (.clock_i(clock_i), .data_i(data_out_o),
    .oe_n_i(data_oe_n_o), .bus_o(bus));
  // --------------------------------------------------------------------
  // clock, checks and verdict
  // --------------------------------------------------------------------
  always #2.5 clock_i = ~clock_i;
  task summarize;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task tally(input ok, input string m);
    samples_checked = samples_checked + 1;
    if (ok !== 1'b1) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task cmp_read(input [8:0] e);
    tally({data_oe_n_o, data_out_o} === e && (e[8] || bus === e[7:0]), "read");
  endtask
  task cmp_val(input got, input e, input string m);
    tally(got === e, m);
  endtask
  // a read result shows after the edge following its request
  always @(posedge clock_i) look <= req;
  always @(negedge clock_i) if (look) cmp_read(notes.pop_front());
  // hang guard
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  // one read request, expected word noted for the result watcher
  task rd(input [9:0] a, input s_n, input in_n);
    @(posedge clock_i);
    word_select_i <= a;
    sync_out_enable_n_i <= s_n;
    init_load_n_i <= in_n;
    req <= 1'b1;
    notes.push_back({s_n | async_out_enable_n_i, in_n ? exp_mem[a] : exp_init});
  endtask
  task idle;
    @(posedge clock_i);
    req <= 1'b0;
  endtask
  task set_async(input v);
    @(posedge clock_i);
    async_out_enable_n_i <= v;
  endtask
  // blows one bit of an array word or of the extra word
  task blow(input pw, input [2:0] b, input [9:0] a);
    @(posedge clock_i);
    async_out_enable_n_i <= 1'b1;
    prog_start_i <= 1'b1;
    prog_init_word_i <= pw;
    prog_bit_i <= b;
    word_select_i <= a;
    @(posedge clock_i);
    prog_start_i <= 1'b0;
    #1 cmp_val(prog_busy_o, 1'b1, "busy");
    for (j = 0; j < 13000 && prog_done_o !== 1'b1; j = j + 1) @(posedge clock_i);
    cmp_val(prog_done_o, 1'b1, "done");
    if (pw) exp_init[b] = 1'b1;
    else exp_mem[a][b] = 1'b1;
  endtask
  initial begin
    for (j = 0; j < 1024; j = j + 1) exp_mem[j] = 8'h00;
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    #1 cmp_read({1'b1, 8'h00});
    set_async(1'b0);
    @(posedge clock_i);
    prog_start_i <= 1'b1;
    @(posedge clock_i);
    prog_start_i <= 1'b0;
    #1 cmp_val(prog_error_o, 1'b1, "refused start");
    for (i = 0; i < 16; i = i + 1) begin
      r = $random(seed);
      rd(r[9:0], r[10], r[11]);
    end
    idle;
    r = $random(seed);
    addr_a = r[9:0];
    blow(1'b0, 3'h3, addr_a);
    blow(1'b0, 3'h3, addr_a);
    blow(1'b0, 3'h6, addr_a);
    blow(1'b1, 3'h5, addr_a);
    set_async(1'b0);
    rd(addr_a, 1'b0, 1'b1);
    rd(addr_a ^ 10'h001, 1'b0, 1'b1);
    rd(addr_a, 1'b0, 1'b0);
    rd(addr_a, 1'b1, 1'b1);
    rd(addr_a, 1'b0, 1'b1);
    idle;
    set_async(1'b1);
    #1 cmp_read({1'b1, exp_mem[addr_a]});
    set_async(1'b0);
    #1 cmp_read({1'b0, exp_mem[addr_a]});
    rd(addr_a, 1'b0, 1'b1);
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge clock_i);
      clk_en_i <= 1'b0;
      word_select_i <= ~addr_a;
      sync_out_enable_n_i <= 1'b1;
      notes.push_back({1'b0, exp_mem[addr_a]});
    end
    @(posedge clock_i);
    clk_en_i <= 1'b1;
    req <= 1'b0;
    repeat (2) @(posedge clock_i);
    summarize;
  end
endmodule // registered_prom_read_test
